// ==== ssp_serial_port.sv ====
// Function
// - interrupt request while enabled and transfer-done or controller-fault flag set
// - port output enable hands pins to the port; fault clears it
// - controller select drives sck and swaps data pins; fault clears it
// - idle level select sets resting sck level in master mode; slave mode does not use it
// - capture phase select picks first or second sck edge for capture
// - master sck is cpu clock divided by four to 128 per rate bits
// - rate bits do nothing in slave mode
// - transfer-done set at byte end; cleared by status then data access
// - data writes ignored while transfer-done flag is set
// - write-clash flag set by data write during a shift
// - fault flag set by low ss in master; cleared by status then control write
// - master transfer starts only on a data register write
// - received byte copied to receive buffer at byte end; reads return it
// - data write loads shift register directly; reads never see it
// - colliding write discarded, running transfer unaffected
// - slave with ss low refuses data writes until ss high
// - while fault set, port enable and controller select cannot be set, except by the control write that clears the fault
`timescale 1ns/1ps
module ssp_serial_port (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // register port
  input  wire ssp_pkg::ssp_bus_t bus,
  output logic [7:0]            rdata,
  // serial clock pin
  input  wire logic             sck_in,
  output logic                  sck_out,
  output logic                  sck_oe,
  // controller-out data pin
  input  wire logic             mosi_in,
  output logic                  mosi_out,
  output logic                  mosi_oe,
  // controller-in data pin
  input  wire logic             miso_in,
  output logic                  miso_out,
  output logic                  miso_oe,
  // slave select, active low
  input  wire logic             ss_n,
  // serial port interrupt request
  output logic                  irq
);

  ssp_pkg::ssp_ctrl_t  ctrl;
  ssp_pkg::ssp_state_t state;
  ssp_pkg::ssp_state_t next_state;

  logic       done_flag;
  logic       clash_flag;
  logic       fault_flag;
  logic       data_seq_armed;
  logic       fault_seq_armed;
  logic [7:0] shreg;
  logic [7:0] rxbuf;
  logic       rx_bit;
  logic [3:0] edge_cnt;
  logic       sck_lvl;
  logic       sck_prev;
  logic       tick;
  logic       last_q;

  logic       is_master;
  logic       port_on;
  logic       wr_data;
  logic       rd_data;
  logic       wr_ctrl;
  logic       stat_access;
  logic       fault_evt;
  logic       m_edge;
  logic       s_edge;
  logic       sh_edge;
  logic       din;
  logic       last_edge;
  logic       sample_edge;
  logic       shift_edge;
  logic       busy;
  logic       dr_load;
  logic       collide;
  logic       start;
  logic       data_clear;
  logic       fault_clear;
  logic [7:0] next_byte;
  logic       ctrl_locked;

  assign is_master   = ctrl.controller_select;
  assign port_on     = ctrl.port_output_enable;
  assign wr_data     = bus.wr && bus.addr == ssp_pkg::SSP_ADDR_DATA;
  assign rd_data     = bus.rd && bus.addr == ssp_pkg::SSP_ADDR_DATA;
  assign wr_ctrl     = bus.wr && bus.addr == ssp_pkg::SSP_ADDR_CTRL;
  // writes to the read-only status count as an access for the clearing sequences
  assign stat_access = (bus.wr || bus.rd) && bus.addr == ssp_pkg::SSP_ADDR_STAT;

  // ss is an input only; a master that sees it low lost the bus
  assign fault_evt = is_master && !ss_n;

  // master edges come from the divider, slave edges from the pin
  assign m_edge  = state == ssp_pkg::SSP_SHIFT && tick;
  assign s_edge  = port_on && !is_master && !ss_n && sck_in != sck_prev;
  assign sh_edge = m_edge || s_edge;

  // master samples miso, slave samples mosi
  assign din = is_master ? miso_in : mosi_in;

  // even edge index is capture with phase 0, odd index with phase 1
  assign sample_edge = sh_edge && edge_cnt[0] == ctrl.capture_phase_select;
  assign last_edge   = sh_edge && edge_cnt == ssp_pkg::SSP_LAST_EDGE;
  // phase 1 has its msb on the pin already, so its first edge moves nothing
  assign shift_edge  = sh_edge && edge_cnt[0] != ctrl.capture_phase_select
                       && !(ctrl.capture_phase_select && edge_cnt == ssp_pkg::SSP_FIRST_EDGE);

  // with phase 1 the last edge is a capture edge, so take the pin directly
  assign next_byte = {shreg[6:0], ctrl.capture_phase_select ? din : rx_bit};

  // a low ss on a slave freezes the data register
  assign busy = is_master ? state == ssp_pkg::SSP_SHIFT : (port_on && !ss_n);

  assign dr_load = wr_data && !done_flag && !busy;
  assign collide = wr_data && !done_flag && busy;
  assign start   = dr_load && is_master && port_on && !fault_evt;

  assign data_clear  = (rd_data || wr_data) && data_seq_armed;
  assign fault_clear = wr_ctrl && fault_seq_armed;
  assign ctrl_locked = fault_flag && !fault_seq_armed;

  ssp_baud u_baud (
    .clk  (clk),
    .nrst (nrst),
    .run  (state == ssp_pkg::SSP_SHIFT),
    .rate ({ctrl.half_divider_select, ctrl.rate_select}),
    .tick (tick)
  );

  // master sequencing
  always_comb begin
    next_state = state;
    case (state)
      ssp_pkg::SSP_IDLE: begin
        if (start) begin
          next_state = ssp_pkg::SSP_SHIFT;
        end
      end
      ssp_pkg::SSP_SHIFT: begin
        if (fault_evt || !is_master || last_edge) begin
          next_state = ssp_pkg::SSP_IDLE;
        end
      end
      default: next_state = ssp_pkg::SSP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ssp_pkg::SSP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // control register; the fault wins over a write in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= ssp_pkg::SSP_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= bus.wdata;
        if (ctrl_locked) begin
          ctrl.port_output_enable <= ctrl.port_output_enable && bus.wdata[6];
          ctrl.controller_select  <= ctrl.controller_select && bus.wdata[4];
        end
      end
      if (fault_evt) begin
        ctrl.port_output_enable <= 1'b0;
        ctrl.controller_select  <= 1'b0;
      end
    end
  end

  // shift register and receive buffer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shreg <= ssp_pkg::SSP_DATA_RESET;
    end else if (dr_load) begin
      shreg <= bus.wdata;
    end else if (last_edge) begin
      shreg <= next_byte;
    end else if (shift_edge) begin
      shreg <= {shreg[6:0], rx_bit};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_bit <= 1'b0;
    end else if (sample_edge) begin
      rx_bit <= din;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxbuf <= ssp_pkg::SSP_DATA_RESET;
    end else if (last_edge) begin
      rxbuf <= next_byte;
    end
  end

  // edge counter; a slave restarts the byte whenever ss goes high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      edge_cnt <= ssp_pkg::SSP_FIRST_EDGE;
    end else if (start || (!is_master && ss_n)) begin
      edge_cnt <= ssp_pkg::SSP_FIRST_EDGE;
    end else if (is_master && state == ssp_pkg::SSP_IDLE) begin
      edge_cnt <= ssp_pkg::SSP_FIRST_EDGE;
    end else if (sh_edge) begin
      edge_cnt <= edge_cnt + 4'h1;
    end
  end

  // serial clock level, resting at the idle level between bytes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_lvl <= 1'b0;
    end else if (next_state == ssp_pkg::SSP_IDLE) begin
      sck_lvl <= ctrl.idle_level_select;
    end else if (m_edge) begin
      sck_lvl <= !sck_lvl;
    end
  end

  // pin history for slave edge detection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= sck_in;
    end
  end

  // transfer-done and write-clash share one clearing sequence
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_flag      <= 1'b0;
      clash_flag     <= 1'b0;
      data_seq_armed <= 1'b0;
    end else begin
      if (last_edge) begin
        done_flag <= 1'b1;
      end else if (data_clear) begin
        done_flag <= 1'b0;
      end
      if (collide) begin
        clash_flag <= 1'b1;
      end else if (data_clear) begin
        clash_flag <= 1'b0;
      end
      if (data_clear) begin
        data_seq_armed <= 1'b0;
      end else if (stat_access && (done_flag || clash_flag)) begin
        data_seq_armed <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_flag      <= 1'b0;
      fault_seq_armed <= 1'b0;
    end else begin
      if (fault_evt) begin
        fault_flag <= 1'b1;
      end else if (fault_clear) begin
        fault_flag <= 1'b0;
      end
      if (wr_ctrl) begin
        fault_seq_armed <= 1'b0;
      end else if (stat_access && fault_flag) begin
        fault_seq_armed <= 1'b1;
      end
    end
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= ssp_pkg::SSP_UNMAPPED;
    end else if (bus.rd) begin
      case (bus.addr)
        ssp_pkg::SSP_ADDR_DATA: rdata <= rxbuf;
        ssp_pkg::SSP_ADDR_CTRL: rdata <= ctrl;
        ssp_pkg::SSP_ADDR_STAT: rdata <= {done_flag, clash_flag, 1'b0, fault_flag, 4'h0};
        default:                rdata <= ssp_pkg::SSP_UNMAPPED;
      endcase
    end else begin
      rdata <= ssp_pkg::SSP_UNMAPPED;
    end
  end

  // a phase 1 byte ends on a capture edge; mosi must not move with that pin edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_q <= 1'b0;
    end else begin
      last_q <= last_edge;
    end
  end

  // pin drivers; enables lag the control bits by one cycle, but fall with them on a fault
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_out  <= 1'b0;
      sck_oe   <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe  <= 1'b0;
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
    end else begin
      sck_out  <= sck_lvl;
      sck_oe   <= port_on && is_master && !fault_evt;
      if (!last_q) begin
        mosi_out <= next_state == ssp_pkg::SSP_IDLE && dr_load ? bus.wdata[7] : shreg[7];
      end
      mosi_oe  <= port_on && is_master && !fault_evt;
      miso_out <= shreg[7];
      miso_oe  <= port_on && !is_master && !ss_n;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= ctrl.xfer_irq_enable && (done_flag || fault_flag);
    end
  end

endmodule

// ==== ssp_pkg.sv ====
package ssp_pkg;

  // register map, byte addresses on the plain register port
  localparam logic [7:0] SSP_ADDR_DATA = 8'h21;
  localparam logic [7:0] SSP_ADDR_CTRL = 8'h22;
  localparam logic [7:0] SSP_ADDR_STAT = 8'h23;

  // reset values
  localparam logic [7:0] SSP_CTRL_RESET = 8'h00;
  localparam logic [7:0] SSP_STAT_RESET = 8'h00;
  localparam logic [7:0] SSP_DATA_RESET = 8'h00;
  localparam logic [7:0] SSP_UNMAPPED   = 8'h00;

  // serial clock half periods in cpu cycles, one per baud setting
  localparam logic [5:0] SSP_HALF_DIV4   = 6'h02;
  localparam logic [5:0] SSP_HALF_DIV8   = 6'h04;
  localparam logic [5:0] SSP_HALF_DIV16  = 6'h08;
  localparam logic [5:0] SSP_HALF_DIV32  = 6'h10;
  localparam logic [5:0] SSP_HALF_DIV64  = 6'h20;
  localparam logic [5:0] SSP_HALF_DIV128 = 6'h40;

  // rate codes {half_divider_select, rate_select}
  localparam logic [2:0] SSP_RATE_DIV4   = 3'h4;
  localparam logic [2:0] SSP_RATE_DIV8   = 3'h0;
  localparam logic [2:0] SSP_RATE_DIV16  = 3'h1;
  localparam logic [2:0] SSP_RATE_DIV32  = 3'h6;
  localparam logic [2:0] SSP_RATE_DIV64  = 3'h2;
  localparam logic [2:0] SSP_RATE_DIV128 = 3'h3;

  // sixteen sck edges per byte, counted 0..15
  localparam logic [3:0] SSP_FIRST_EDGE = 4'h0;
  localparam logic [3:0] SSP_LAST_EDGE  = 4'hF;

  // control register, bit 7 down to bit 0
  typedef struct packed {
    logic       xfer_irq_enable;
    logic       port_output_enable;
    logic       half_divider_select;
    logic       controller_select;
    logic       idle_level_select;
    logic       capture_phase_select;
    logic [1:0] rate_select;
  } ssp_ctrl_t;

  // status register, bit 7 down to bit 0
  typedef struct packed {
    logic       transfer_done_flag;
    logic       write_clash_flag;
    logic       unused5;
    logic       controller_fault_flag;
    logic [3:0] unused;
  } ssp_stat_t;

  // one register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ssp_bus_t;

  typedef enum logic {
    SSP_IDLE  = 1'b0,
    SSP_SHIFT = 1'b1
  } ssp_state_t;

endpackage

// ==== ssp_baud.sv ====
`timescale 1ns/1ps
module ssp_baud (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // control
  input  wire logic       run,
  input  wire logic [2:0] rate,
  // one-cycle pulse at each sck edge
  output logic            tick
);

  logic [5:0] count;
  logic [5:0] half;

  function automatic logic [5:0] ssp_half_of(input logic [2:0] code);
    case (code)
      ssp_pkg::SSP_RATE_DIV4:   ssp_half_of = ssp_pkg::SSP_HALF_DIV4;
      ssp_pkg::SSP_RATE_DIV8:   ssp_half_of = ssp_pkg::SSP_HALF_DIV8;
      ssp_pkg::SSP_RATE_DIV16:  ssp_half_of = ssp_pkg::SSP_HALF_DIV16;
      ssp_pkg::SSP_RATE_DIV32:  ssp_half_of = ssp_pkg::SSP_HALF_DIV32;
      ssp_pkg::SSP_RATE_DIV64:  ssp_half_of = ssp_pkg::SSP_HALF_DIV64;
      ssp_pkg::SSP_RATE_DIV128: ssp_half_of = ssp_pkg::SSP_HALF_DIV128;
      // two codes have no documented rate; fall back to /8
      default:                  ssp_half_of = ssp_pkg::SSP_HALF_DIV8;
    endcase
  endfunction

  assign half = ssp_half_of(rate);

  // restarts with every transfer so the first edge is a full half period late
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= 6'h00;
      tick  <= 1'b0;
    end else if (!run) begin
      count <= 6'h00;
      tick  <= 1'b0;
    end else if (count == half - 6'h01) begin
      count <= 6'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 6'h01;
      tick  <= 1'b0;
    end
  end

endmodule

// ==== ssp_checker.sv ====
`timescale 1ns/1ps
module ssp_checker (
  // clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // register port
  input wire ssp_pkg::ssp_bus_t bus,
  input wire logic [7:0]        rdata,
  // pins
  input wire logic              sck_out,
  input wire logic              sck_oe,
  input wire logic              mosi_oe,
  input wire logic              miso_oe,
  input wire logic              ss_n,
  input wire logic              irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  localparam logic [7:0] AC = ssp_pkg::SSP_ADDR_CTRL;
  localparam logic [7:0] AS = ssp_pkg::SSP_ADDR_STAT;

  sequence rd_of(logic [7:0] a);
    bus.rd && bus.addr == a;
  endsequence

  chk_rdata_quiet: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside its slot");
  chk_stat_unused: assert property (rd_of(AS) |=> rdata[5] == 1'b0 && rdata[3:0] == 4'h0)
    else $error("unused status bits not zero");
  chk_irq_gate: assert property (rd_of(AC) ##1 !rdata[7] |-> !irq)
    else $error("irq while disabled");
  chk_irq_cause: assert property (rd_of(AS) ##1 (!rdata[7] && !rdata[4]) |-> !irq)
    else $error("irq without a flag");
  chk_master_pins: assert property (sck_oe |-> mosi_oe && !miso_oe)
    else $error("master pin roles wrong");
  chk_sck_half: assert property (sck_oe && $changed(sck_out) |=> $stable(sck_out) || $fell(sck_oe))
    else $error("sck half period below two cycles");
  chk_miso_sel: assert property (ss_n && $past(ss_n) |-> !miso_oe)
    else $error("miso driven while not selected");
  chk_fault_off: assert property (sck_oe && !ss_n |-> ##[1:3] !sck_oe)
    else $error("outputs kept on after fault");
  chk_sck_rest: assert property (!sck_oe && !$past(sck_oe) && !$past(bus.wr) && !$past(bus.wr, 2)
    |-> $stable(sck_out))
    else $error("sck moved while not driven");
endmodule

// ==== ssp_far_slave.sv ====
`timescale 1ns/1ps
module ssp_far_slave (
  // serial pins
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  output logic            miso,
  // mode and data
  input  wire logic       pol,
  input  wire logic       pha,
  input  wire logic [7:0] tx,
  output logic [7:0]      rx
);
  logic [7:0] sh;
  logic       started;
  wire        lead = sck ^ pol;
  initial begin
    miso = 1'b0;
    rx = 8'h00;
  end
  // each byte framed by its own select pulse
  always @(negedge sel_n) begin
    sh = tx;
    started = 1'b0;
    if (!pha) miso = tx[7];
  end
  // released line must not keep showing the stale bit
  always @(posedge sel_n) miso = ~miso;
  always @(posedge lead) if (!sel_n) begin
    if (!pha) rx = {rx[6:0], mosi};
    else begin
      if (started) sh = sh << 1;
      started = 1'b1;
      miso = sh[7];
    end
  end
  always @(negedge lead) if (!sel_n) begin
    if (pha) rx = {rx[6:0], mosi};
    else begin
      sh = sh << 1;
      miso = sh[7];
    end
  end
endmodule

// ==== spi_serial_port_tb.sv ====
`timescale 1ns/1ps
module spi_serial_port_tb;
  localparam logic [7:0] AD = ssp_pkg::SSP_ADDR_DATA;
  localparam logic [7:0] AC = ssp_pkg::SSP_ADDR_CTRL;
  localparam logic [7:0] AS = ssp_pkg::SSP_ADDR_STAT;
  logic              clk = 0, nrst = 0, ss_n = 1, tsck = 0, tmosi = 0;
  logic              psel_n = 1, pol = 0, pha = 0, pmiso;
  ssp_pkg::ssp_bus_t bus = '0;
  logic [7:0]        rdata, prx, ptx = 8'h00;
  logic              sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq;
  wire               sck_w  = sck_oe ? sck_out : tsck;
  wire               mosi_w = mosi_oe ? mosi_out : tmosi;
  wire               miso_w = miso_oe ? miso_out : pmiso;
  int                failures = 0, cmp_count = 0;

  always #2 clk = ~clk;

  ssp_serial_port i_dut (.clk, .nrst, .bus, .rdata, .sck_in(sck_w), .sck_out, .sck_oe,
    .mosi_in(mosi_w), .mosi_out, .mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe, .ss_n, .irq);
  ssp_far_slave i_far (.sck(sck_w), .mosi(mosi_w), .sel_n(psel_n), .miso(pmiso), .pol, .pha,
    .tx(ptx), .rx(prx));

  task automatic chk(input logic [7:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // a gap cycle after every strobe keeps each strobe one cycle long
  task automatic wr(input logic [7:0] a, d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask

  task automatic rc(input logic [7:0] a, exp);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    chk(rdata, exp, "read");
    @(posedge clk);
  endtask

  task automatic wdone;
    for (int k = 0; k < 3000 && irq !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
  endtask

  task automatic t_regs;
    rc(AC, 8'h00);
    rc(AS, 8'h00);
    rc(AD, 8'h00);
    rc(8'h30, 8'h00);
    wr(AS, 8'hFF);
    rc(AS, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_master;
    logic [2:0] c [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
    logic [7:0] tx, n;
    for (int i = 0; i < 6; i++) begin
      tx = 8'h96 ^ 8'(i * 37);
      pol <= i[1];
      pha <= i[0];
      ptx <= ~tx;
      wr(AC, {2'b11, c[i][2], 1'b1, i[1:0], c[i][1:0]});
      repeat (2) @(posedge clk);
      psel_n <= 1'b0;
      wr(AD, tx);
      n = 0;
      while (sck_out === i[1] && n < 200) begin
        @(posedge clk);
        #1;
        n++;
      end
      n = 0;
      while (sck_out !== i[1] && n < 200) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk(n, 8'h02 << i, "half period");
      wdone();
      psel_n <= 1'b1;
      chk({7'h0, irq}, 8'h01, "irq");
      chk(prx, tx, "far rx");
      rc(AS, 8'h80);
      rc(AD, ~tx);
      rc(AS, 8'h00);
      chk({7'h0, sck_out}, {7'h0, i[1]}, "idle");
    end
    $display("test master done");
  endtask

  task automatic t_clash;
    pol <= 1'b0;
    pha <= 1'b0;
    ptx <= 8'h5A;
    wr(AC, 8'hD0);
    repeat (2) @(posedge clk);
    psel_n <= 1'b0;
    wr(AD, 8'hC3);
    wr(AD, 8'h0F);
    wdone();
    psel_n <= 1'b1;
    chk(prx, 8'hC3, "far rx");
    wr(AD, 8'h77);
    rc(AS, 8'hC0);
    rc(AD, 8'h5A);
    repeat (80) @(posedge clk);
    chk({7'h0, sck_out}, 8'h00, "no start");
    rc(AS, 8'h00);
    $display("test clash done");
  endtask

  task automatic t_fault;
    wr(AC, 8'hD0);
    ss_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({7'h0, irq}, 8'h01, "fault irq");
    @(posedge clk);
    ss_n <= 1'b1;
    rc(AC, 8'h80);
    wr(AC, 8'hD0);
    rc(AC, 8'h80);
    rc(AS, 8'h10);
    wr(AC, 8'h50);
    rc(AS, 8'h00);
    rc(AC, 8'h50);
    $display("test fault done");
  endtask

  task automatic t_slave;
    logic [7:0] v, mb;
    mb = 8'h6B;
    wr(AC, 8'h43);
    wr(AD, 8'hA5);
    ss_n <= 1'b0;
    @(posedge clk);
    wr(AD, 8'h11);
    for (int b = 7; b >= 0; b--) begin
      tmosi <= mb[b];
      repeat (4) @(posedge clk);
      tsck <= 1'b1;
      v[b] = miso_w;
      repeat (4) @(posedge clk);
      tsck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    ss_n <= 1'b1;
    chk(v, 8'hA5, "slave tx");
    rc(AC, 8'h43);
    rc(AS, 8'hC0);
    rc(AD, 8'h6B);
    $display("test slave done");
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_master();
    t_clash();
    t_fault();
    t_slave();
    tally_and_finish();
  end

  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
endmodule

bind ssp_serial_port ssp_checker i_chk (.clk, .nrst, .bus, .rdata, .sck_out, .sck_oe,
  .mosi_oe, .miso_oe, .ss_n, .irq);
